// [rtl/wwd_defs.svh]
// wwd_defs.svh - offsets, bit positions, reset values and counts of the watchdog
// assumes: included by bare name from the design modules
`ifndef WWD_DEFS_SVH
`define WWD_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define WWD_OFS_MODE      8'h00
`define WWD_OFS_RELOAD    8'h04
`define WWD_OFS_FEED      8'h08
`define WWD_OFS_COUNT     8'h0C
`define WWD_OFS_WARN      8'h14
`define WWD_OFS_WINDOW    8'h18
// ----------------------------------------
// mode_control bit positions
// ----------------------------------------
`define WWD_BIT_RUN       0
`define WWD_BIT_RESET     1
`define WWD_BIT_TIMEOUT   2
`define WWD_BIT_WARNING   3
`define WWD_BIT_PROTECT   4
// ----------------------------------------
// reset values and constants
// ----------------------------------------
`define WWD_RST_RELOAD    24'h0000FF
`define WWD_RST_COUNT     24'h0000FF
`define WWD_RST_WARN      10'h000
`define WWD_RST_WINDOW    24'hFFFFFF
`define WWD_MIN_LOAD      24'h0000FF
`define WWD_FEED_KEY1     8'hAA
`define WWD_FEED_KEY2     8'h55
`define WWD_PRESC_LAST    2'h3
`endif

// [rtl/wwd_pkg.sv]
// wwd_pkg.sv - types shared by the watchdog modules
// assumes: nothing from wwd_defs.svh; the package uses no constants
package wwd_pkg;
   // ----------------------------------------
   // feed sequence state
   // ----------------------------------------
   typedef enum logic [0:0] {
      WWD_FEED_IDLE  = 1'b0,
      WWD_FEED_ARMED = 1'b1
   } wwd_feed_t;

   // ----------------------------------------
   // state records
   // ----------------------------------------
   typedef struct packed {
      logic [1:0] stage1;
      logic [1:0] stage2;
      logic       tick_prev;
      logic       tick;
   } wwd_sync_st_t;

   typedef struct packed {
      logic [1:0]  presc;
      logic [23:0] count;
      logic        warn_hit;
      logic        zero_hit;
   } wwd_cnt_st_t;

   typedef struct packed {
      logic        run_set;
      logic        rst_set;
      logic        prot_set;
      logic        run_act;
      logic        rst_act;
      logic        prot_act;
      logic        tof;
      logic        warn;
      logic        started;
      wwd_feed_t   feed;
      logic [23:0] reload;
      logic [23:0] window;
      logic [9:0]  warn_val;
      logic [31:0] rdata;
      logic        pready;
      logic        chip_rst;
      logic        irq;
      logic        wake;
      logic        lock;
      logic        load;
   } wwd_top_st_t;
endpackage : wwd_pkg

// [rtl/wwd_cnt_if.sv]
// wwd_cnt_if.sv - link between the register logic and the down counter
// assumes: both ends run on the same clock
`timescale 1ns/10ps
interface wwd_cnt_if;
   logic        tick;
   logic        load;
   logic [23:0] load_val;
   logic        run;
   logic [9:0]  warn_val;
   logic [23:0] count;
   logic        warn_hit;
   logic        zero_hit;

   modport cnt (input tick, load, load_val, run, warn_val,
                output count, warn_hit, zero_hit);
   modport ctl (output tick, load, load_val, run, warn_val,
                input count, warn_hit, zero_hit);
endinterface : wwd_cnt_if

// [rtl/wwd_sync.sv]
// wwd_sync.sv - two-flop synchronisers for the counting clock and sleep pins
// assumes: pins are asynchronous to clk_i and far slower than it
`timescale 1ns/10ps
`include "wwd_defs.svh"
module wwd_sync import wwd_pkg::*; (
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   input  wire logic cnt_clk_pin_i,
   input  wire logic sleep_pin_i,
   output logic      tick_o,
   output logic      sleep_o
);
   wwd_sync_st_t s_q, s_d;

   // ----------------------------------------
   // edge detect reads only the second stage
   // ----------------------------------------
   always_comb begin
      s_d           = s_q;
      s_d.stage1    = {sleep_pin_i, cnt_clk_pin_i};
      s_d.stage2    = s_q.stage1;
      s_d.tick_prev = s_q.stage2[0];
      s_d.tick      = s_q.stage2[0] & ~s_q.tick_prev;   // R25
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick_o  = s_q.tick;
   assign sleep_o = s_q.stage2[1];
endmodule : wwd_sync

// [rtl/wwd_counter.sv]
// wwd_counter.sv - divide-by-4 prescaler and 24-bit down counter
// assumes: tick is a one-cycle pulse per counting clock rising edge
`timescale 1ns/10ps
`include "wwd_defs.svh"
module wwd_counter import wwd_pkg::*; (
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   wwd_cnt_if.cnt    cif
);
   wwd_cnt_st_t s_q, s_d;
   logic [23:0] next_cnt;

   // warning match: low ten bits equal, upper bits all zero
   function automatic logic warn_match(input logic [23:0] c, input logic [9:0] w);
      warn_match = (c[23:10] == 14'h0) && (c[9:0] == w);
   endfunction : warn_match

   // ----------------------------------------
   // counting
   // ----------------------------------------
   always_comb begin
      s_d          = s_q;
      s_d.warn_hit = 1'b0;
      s_d.zero_hit = 1'b0;
      next_cnt     = s_q.count - 24'h000001;
      if (cif.load) begin
         s_d.count = cif.load_val;                         // R1
         s_d.presc = 2'h0;
      end else if (cif.run && cif.tick) begin              // R23
         s_d.presc = s_q.presc + 2'h1;
         // parks at zero so one time-out is reported once
         if (s_q.presc == `WWD_PRESC_LAST && s_q.count != 24'h000000) begin
            s_d.count    = next_cnt;
            s_d.warn_hit = warn_match(next_cnt, cif.warn_val);   // R24
            s_d.zero_hit = (next_cnt == 24'h000000);
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_q <= '{presc: 2'h0, count: `WWD_RST_COUNT, warn_hit: 1'b0, zero_hit: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign cif.count    = s_q.count;
   assign cif.warn_hit = s_q.warn_hit;
   assign cif.zero_hit = s_q.zero_hit;
endmodule : wwd_counter

// [rtl/wwd_top.sv]
// wwd_top.sv - windowed watchdog: register file, feed check and mode logic
// assumes: APB-style register port on clk_i; counting clock and sleep are pins
//
// Summary of operation
// R1 - feed 0xAA then 0x55 reloads counter
// R2 - counter value readable, read only
// R3 - mode writes act after next feed
// R4 - run enable bit zero set only
// R5 - run enable locks clock source choice
// R6 - reset enable bit one, set only
// R7 - time-out flag set by events, cleared by external reset
// R8 - writing zero clears time-out flag
// R9 - warning flag set at warning match
// R10 - warning flag cleared by reset, write one
// R11 - protect limits reload changes to late window
// R12 - early protected reload write sets time-out
// R13 - software pairs protect with reset enable
// R14 - mode bits clear only on resets
// R15 - run disabled: no interrupt, no reset
// R16 - interrupt mode: warning flag and interrupt
// R17 - reset mode: reset at counter zero
// R18 - early feed in reset mode resets chip
// R19 - interrupt during sleep raises wake request
// R20 - reset values of reload, count, compares
// R21 - broken feed sequence causes time-out event
// R22 - counting starts only after valid feed
// R23 - 24-bit counter, divide-by-4 prescaler
// R24 - warning match on low ten bits
// R25 - pins synchronised before logic uses them
`timescale 1ns/10ps
`include "wwd_defs.svh"
module wwd_top import wwd_pkg::*; (
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        counting_clock_i,
   input  wire logic        sleep_i,
   output logic             chip_reset_o,
   output logic             irq_o,
   output logic             wake_o,
   output logic             clksel_lock_o
);
   // ----------------------------------------
   // submodules
   // ----------------------------------------
   wwd_cnt_if   cif ();
   wwd_top_st_t s_q, s_d;
   logic        tick;
   logic        sleep_s;
   logic        slverr_q;

   wwd_sync u_sync (
      .clk_i         (clk_i),
      .reset_n_i     (reset_n_i),
      .cnt_clk_pin_i (counting_clock_i),
      .sleep_pin_i   (sleep_i),
      .tick_o        (tick),
      .sleep_o       (sleep_s)
   );

   wwd_counter u_counter (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .cif       (cif.cnt)
   );

   // address compare shared by the feed and reload write decodes
   function automatic logic at(input logic [7:0] a, input logic [7:0] ofs);
      at = (a == ofs);
   endfunction : at

   // ----------------------------------------
   // bus decode and event terms
   // ----------------------------------------
   logic acc;
   logic wr;
   logic rd_setup;
   logic feed_ok;
   logic feed_err;
   logic zero_ev;
   logic window_ev;
   logic prot_ok;
   logic prot_err;
   logic tof_ev;
   logic rst_req;
   logic [23:0] wdat24;

   always_comb begin
      acc      = psel_i & penable_i & s_q.pready;
      wr       = acc & pwrite_i;
      rd_setup = psel_i & ~penable_i & ~pwrite_i;
      wdat24   = pwdata_i[23:0];
      // second key must be the very next access
      feed_ok  = wr && at(paddr_i, `WWD_OFS_FEED) &&
                 pwdata_i[7:0] == `WWD_FEED_KEY2 && s_q.feed == WWD_FEED_ARMED;   // R1
      feed_err = acc && s_q.feed == WWD_FEED_ARMED && !feed_ok
                 && s_q.run_act && s_q.started;                                  // R21 R22
      zero_ev  = cif.zero_hit & s_q.run_act & s_q.started;                        // R15
      // too-early feed only counts once windowing is live in reset mode
      window_ev = feed_ok && s_q.run_act && s_q.rst_act && s_q.started &&
                  cif.count > s_q.window;                                        // R18
      prot_ok  = cif.count < {14'h0, s_q.warn_val} && cif.count < s_q.window;     // R11
      prot_err = wr && at(paddr_i, `WWD_OFS_RELOAD) && s_q.prot_act && !prot_ok;  // R12
      tof_ev   = zero_ev | feed_err | window_ev | prot_err;                       // R7
      rst_req  = tof_ev & s_q.run_act & s_q.rst_act;                              // R17 R6
   end

   // ----------------------------------------
   // next-state logic
   // ----------------------------------------
   always_comb begin
      s_d          = s_q;
      s_d.load     = 1'b0;
      s_d.chip_rst = 1'b0;
      s_d.pready   = 1'b1;

      // feed sequence tracking
      if (feed_ok || (acc && s_q.feed == WWD_FEED_ARMED)) begin
         s_d.feed = WWD_FEED_IDLE;
      end else if (wr && at(paddr_i, `WWD_OFS_FEED) &&
                   pwdata_i[7:0] == `WWD_FEED_KEY1) begin
         s_d.feed = WWD_FEED_ARMED;
      end

      // valid feed: reload and apply pending mode
      if (feed_ok) begin
         s_d.load     = 1'b1;                                   // R1
         s_d.run_act  = s_q.run_set;                            // R3
         s_d.rst_act  = s_q.rst_set;                            // R3
         s_d.prot_act = s_q.prot_set;                           // R3
         s_d.started  = s_q.run_set;                            // R22
      end

      // register writes
      if (wr) begin
         unique case (paddr_i)
            `WWD_OFS_MODE: begin
               // set-only bits only ever OR in
               s_d.run_set  = s_q.run_set  | pwdata_i[`WWD_BIT_RUN];      // R4 R14
               s_d.rst_set  = s_q.rst_set  | pwdata_i[`WWD_BIT_RESET];    // R6 R14
               s_d.prot_set = s_q.prot_set | pwdata_i[`WWD_BIT_PROTECT];  // R14
               if (!pwdata_i[`WWD_BIT_TIMEOUT]) begin
                  s_d.tof = 1'b0;                                         // R8
               end
               if (pwdata_i[`WWD_BIT_WARNING]) begin
                  s_d.warn = 1'b0;                                        // R10
               end
            end
            `WWD_OFS_RELOAD: begin
               if (!s_q.prot_act || prot_ok) begin                        // R11
                  s_d.reload = (wdat24 < `WWD_MIN_LOAD) ? `WWD_MIN_LOAD : wdat24;
               end
            end
            `WWD_OFS_WARN: begin
               s_d.warn_val = pwdata_i[9:0];
            end
            `WWD_OFS_WINDOW: begin
               s_d.window = wdat24;
            end
            default: begin
               // feed, counter and unmapped writes store nothing here
            end
         endcase
      end

      // hardware sets win over a same-cycle software clear
      if (tof_ev) begin
         s_d.tof = 1'b1;                                        // R7
      end
      if (cif.warn_hit && s_q.run_act && s_q.started) begin
         s_d.warn = 1'b1;                                       // R9 R16
      end

      // watchdog reset wipes mode bits but keeps the time-out flag
      if (rst_req) begin
         s_d.chip_rst = 1'b1;                                   // R17 R18
         s_d.run_set  = 1'b0;                                   // R14
         s_d.rst_set  = 1'b0;
         s_d.prot_set = 1'b0;
         s_d.run_act  = 1'b0;
         s_d.rst_act  = 1'b0;
         s_d.prot_act = 1'b0;
         s_d.started  = 1'b0;
         s_d.warn     = 1'b0;                                   // R10
         s_d.feed     = WWD_FEED_IDLE;
      end

      // read data captured in the setup phase, valid in the access phase
      if (rd_setup) begin
         unique case (paddr_i)
            `WWD_OFS_MODE:   s_d.rdata = {27'h0, s_q.prot_set, s_q.warn,
                                          s_q.tof, s_q.rst_set, s_q.run_set};
            `WWD_OFS_RELOAD: s_d.rdata = {8'h00, s_q.reload};
            `WWD_OFS_COUNT:  s_d.rdata = {8'h00, cif.count};                 // R2
            `WWD_OFS_WARN:   s_d.rdata = {22'h0, s_q.warn_val};
            `WWD_OFS_WINDOW: s_d.rdata = {8'h00, s_q.window};
            default:         s_d.rdata = 32'h00000000;  // feed is write-only
         endcase
      end

      // interrupt only while running; wake follows it in sleep
      s_d.irq  = s_d.run_act & (s_d.warn | s_d.tof);             // R15 R16
      s_d.wake = s_d.irq & sleep_s;                              // R19
      s_d.lock = s_d.run_set;                                    // R5
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_q          <= '0;
         s_q.feed     <= WWD_FEED_IDLE;
         s_q.reload   <= `WWD_RST_RELOAD;                       // R20
         s_q.window   <= `WWD_RST_WINDOW;                       // R20
         s_q.warn_val <= `WWD_RST_WARN;                         // R20
         s_q.pready   <= 1'b1;
         slverr_q     <= 1'b0;
      end else begin
         s_q          <= s_d;
         slverr_q     <= 1'b0;   // unmapped reads answer zero, never an error
      end
   end

   // ----------------------------------------
   // counter link and outputs
   // ----------------------------------------
   assign cif.tick     = tick;                                  // R25
   assign cif.load     = s_q.load;
   assign cif.load_val = s_q.reload;
   assign cif.run      = s_q.run_act & s_q.started;             // R15 R22
   assign cif.warn_val = s_q.warn_val;

   assign prdata_o      = s_q.rdata;
   assign pready_o      = s_q.pready;
   assign pslverr_o     = slverr_q;
   assign chip_reset_o  = s_q.chip_rst;
   assign irq_o         = s_q.irq;
   assign wake_o        = s_q.wake;
   assign clksel_lock_o = s_q.lock;
endmodule : wwd_top

// [tb/wwd_chk.sv]
// wwd_chk.sv - port-level timing checks for the watchdog top
// assumes: bound to wwd_top; one clock, async active-low reset
`timescale 1ns/10ps
module wwd_chk (
   input wire logic        clk_i,
   input wire logic        reset_n_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        counting_clock_i,
   input wire logic        sleep_i,
   input wire logic        chip_reset_o,
   input wire logic        irq_o,
   input wire logic        wake_o,
   input wire logic        clksel_lock_o
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking dc @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   logic acc_rd;
   // access phase of a read; data was captured at setup
   assign acc_rd = psel_i && penable_i && !pwrite_i;

   a_lock_sticky: assert property ($fell(clksel_lock_o) |->
      chip_reset_o || $past(chip_reset_o) || $past(chip_reset_o, 2))
      else $error("lock dropped without watchdog reset");
   a_lock_on_write: assert property (psel_i && penable_i && pwrite_i &&
      paddr_i == 8'h00 && pwdata_i[0] |-> ##[1:2] clksel_lock_o)
      else $error("run enable write did not lock clock source");
   a_reset_pulse: assert property (chip_reset_o |=> !chip_reset_o)
      else $error("chip reset longer than one cycle");
   a_quiet_off: assert property ((!clksel_lock_o)[*3] |-> !irq_o && !chip_reset_o)
      else $error("activity while run enable clear");
   a_reset_run: assert property ($rose(chip_reset_o) |-> $past(clksel_lock_o))
      else $error("chip reset without run enable");
   a_wake_irq: assert property (wake_o |-> irq_o)
      else $error("wake without interrupt");
   a_wake_sleep: assert property (sleep_i[*5] ##0 irq_o |-> wake_o)
      else $error("interrupt in sleep gave no wake");
   a_feed_reads0: assert property (acc_rd && paddr_i == 8'h08 |-> prdata_o == 32'h0)
      else $error("feed register read not zero");

   c_reset: cover property ($rose(chip_reset_o));
   c_irq: cover property ($rose(irq_o));
   c_wake: cover property ($rose(wake_o));
endmodule : wwd_chk

bind wwd_top wwd_chk u_chk (.clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i,
   .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .counting_clock_i,
   .sleep_i, .chip_reset_o, .irq_o, .wake_o, .clksel_lock_o);

// [tb/wwd_host.sv]
// wwd_host.sv - processor model driving the watchdog register port
// assumes: shares clk_i; tb owns the mismatch counter and test_done
`timescale 1ns/10ps
module wwd_host (
   input  wire logic        clk_i,
   input  wire logic [31:0] prdata_i,
   input  wire logic        pready_i,
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic [7:0]       paddr_o,
   output logic [31:0]      pwdata_o
);
   // ----------------------------------------
   // bus cycles
   // ----------------------------------------
   // idle bus at time zero
   initial begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 8'h00;
      pwdata_o = 32'h0;
   end

   // setup, access, hold until ready; data lines flip once released
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      int n;
      @(posedge clk_i);
      psel_o <= 1'b1;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge clk_i);
      penable_o <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_i !== 1'b1 && n < 50);
      q = prdata_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      pwdata_o <= ~d;
      if (n >= 50) begin
         tb.n_mismatch++;
         tb.test_done();
      end
   endtask : xfer

   // the two-write key; any other access between them breaks it
   task automatic feed();
      logic [31:0] q;
      xfer(1'b1, 8'h08, 32'h000000AA, q);
      xfer(1'b1, 8'h08, 32'h00000055, q);
   endtask : feed
endmodule : wwd_host

// [tb/wwd_tb.sv]
// wwd_tb.sv - self-checking bench for the windowed watchdog
// assumes: wwd_host model and bound checker compiled before
`timescale 1ns/10ps
module tb;
   logic        clk_i, reset_n_i, psel_i, penable_i, pwrite_i;
   logic [7:0]  paddr_i;
   logic [31:0] pwdata_i, prdata_o;
   logic        pready_o, pslverr_o, counting_clock_i, sleep_i;
   logic        chip_reset_o, irq_o, wake_o, clksel_lock_o, saw_rst;
   logic [1:0]  div_q;
   int          n_mismatch = 0;
   int          check_count = 0;

   // ----------------------------------------
   // clocks and instances
   // ----------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // counting clock at a quarter of clk_i, slow enough for the synchroniser
   initial div_q = 2'h0;
   always @(posedge clk_i) div_q <= div_q + 2'h1;
   assign counting_clock_i = div_q[1];
   // sticky record of any watchdog reset pulse
   always @(posedge clk_i) if (chip_reset_o === 1'b1) saw_rst <= 1'b1;

   wwd_top uut (.clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .counting_clock_i, .sleep_i,
      .chip_reset_o, .irq_o, .wake_o, .clksel_lock_o);
   wwd_host host (.clk_i, .prdata_i(prdata_o), .pready_i(pready_o), .psel_o(psel_i),
      .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i),
      .pwdata_o(pwdata_i));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      host.xfer(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      host.xfer(1'b1, a, d, q);
   endtask : wr
   // bounded wait for irq (1) or chip reset (0); running out ends the run
   task automatic wait_on(input bit use_irq, input int lim);
      int n;
      n = 0;
      while (((use_irq ? irq_o : chip_reset_o) !== 1'b1) && n < lim) begin
         @(negedge clk_i);
         n++;
      end
      if (n >= lim) begin
         n_mismatch++;
         test_done();
      end
   endtask : wait_on
   task automatic ext_reset();
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      reset_n_i <= 1'b1;
      saw_rst = 1'b0;
   endtask : ext_reset
   task automatic test_done();
      $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset_vals();
      ext_reset();
      rd(8'h00, 32'h0);
      rd(8'h04, 32'hFF);
      rd(8'h08, 32'h0);
      rd(8'h0C, 32'hFF);
      rd(8'h14, 32'h0);
      rd(8'h18, 32'hFFFFFF);
      wr(8'h0C, 32'h1234);
      chk({31'h0, pslverr_o}, 32'h0);
      rd(8'h0C, 32'hFF);
      rd(8'h10, 32'h0);
      wr(8'h04, 32'h10);
      rd(8'h04, 32'hFF);
   endtask : t_reset_vals
   // run set but never fed: no count, broken key ignored
   task automatic t_not_started();
      ext_reset();
      wr(8'h00, 32'h1);
      wr(8'h08, 32'hAA);
      rd(8'h04, 32'hFF);
      rd(8'h00, 32'h1);
      repeat (100) @(posedge clk_i);
      rd(8'h0C, 32'hFF);
      chk({31'h0, irq_o}, 32'h0);
   endtask : t_not_started
   // interrupt mode; high counter bits keep 0x4F0 from matching
   task automatic t_int_mode();
      logic [31:0] q;
      ext_reset();
      sleep_i <= 1'b1;
      wr(8'h14, 32'hF0);
      wr(8'h04, 32'h4F5);
      rd(8'h04, 32'h4F5);
      wr(8'h00, 32'h1);
      host.feed();
      wait_on(1'b1, 20000);
      chk({31'h0, wake_o}, 32'h1);
      host.xfer(1'b0, 8'h0C, 32'h0, q);
      chk({31'h0, q <= 32'hF0 && q >= 32'hEE}, 32'h1);
      rd(8'h00, 32'h9);
      wr(8'h00, 32'h8);
      rd(8'h00, 32'h1);
      chk({31'h0, irq_o}, 32'h0);
      chk({31'h0, clksel_lock_o}, 32'h1);
      wait_on(1'b1, 5000);
      rd(8'h00, 32'h5);
      rd(8'h0C, 32'h0);
      chk({31'h0, saw_rst}, 32'h0);
      wr(8'h00, 32'h0);
      rd(8'h00, 32'h1);
      sleep_i <= 1'b0;
   endtask : t_int_mode
   // reset bit waits for a feed; broken key then resets the chip
   task automatic t_mode_delay();
      ext_reset();
      wr(8'h00, 32'h1);
      host.feed();
      wr(8'h00, 32'h3);
      wr(8'h08, 32'hAA);
      rd(8'h04, 32'hFF);
      rd(8'h00, 32'h7);
      chk({31'h0, irq_o}, 32'h1);
      chk({31'h0, saw_rst}, 32'h0);
      wr(8'h00, 32'h0);
      host.feed();
      wr(8'h08, 32'hAA);
      wr(8'h14, 32'h0);
      wait_on(1'b0, 10);
      rd(8'h00, 32'h4);
   endtask : t_mode_delay
   task automatic t_window();
      ext_reset();
      wr(8'h18, 32'h80);
      wr(8'h00, 32'h3);
      host.feed();
      host.feed();
      wait_on(1'b0, 10);
      rd(8'h00, 32'h4);
   endtask : t_window
   task automatic t_protect();
      ext_reset();
      wr(8'h00, 32'h13);
      host.feed();
      wr(8'h04, 32'h300);
      wait_on(1'b0, 10);
      rd(8'h04, 32'hFF);
      rd(8'h00, 32'h4);
   endtask : t_protect
   // reset mode runs down to zero; protect lets a late reload through
   task automatic t_zero_reset();
      ext_reset();
      wr(8'h14, 32'h10);
      wr(8'h00, 32'h13);
      host.feed();
      wait_on(1'b1, 5000);
      // count must drop below the warning value before the reload write
      repeat (20) @(posedge clk_i);
      wr(8'h04, 32'h300);
      rd(8'h04, 32'h300);
      chk({31'h0, saw_rst}, 32'h0);
      wait_on(1'b0, 400);
      rd(8'h00, 32'h4);
   endtask : t_zero_reset

   // main sequence
   initial begin
      reset_n_i = 1'b0;
      sleep_i = 1'b0;
      saw_rst = 1'b0;
      t_reset_vals();
      t_not_started();
      t_int_mode();
      t_mode_delay();
      t_window();
      t_protect();
      t_zero_reset();
      test_done();
   end
endmodule : tb
